// ==== mcx_defs.vh ====
`ifndef MCX_DEFS_VH
`define MCX_DEFS_VH

// operation select codes
`define MCX_OP_W 5
`define MCX_OP_IDLE 5'h00
`define MCX_OP_COPY_MEM_ACC 5'h01
`define MCX_OP_COPY_LIT_ACC 5'h02
`define MCX_OP_COPY_ACC_MEM 5'h03
`define MCX_OP_OR_MEM 5'h04
`define MCX_OP_OR_LIT 5'h05
`define MCX_OP_OR_TO_MEM 5'h06
`define MCX_OP_POP_PC 5'h07
`define MCX_OP_POP_PC_LIT 5'h08
`define MCX_OP_ROL 5'h09
`define MCX_OP_ROL_ACC 5'h0a
`define MCX_OP_ROLC 5'h0b
`define MCX_OP_ROLC_ACC 5'h0c
`define MCX_OP_ROR 5'h0d
`define MCX_OP_ROR_ACC 5'h0e
`define MCX_OP_RORC 5'h0f
`define MCX_OP_RORC_ACC 5'h10
`define MCX_OP_SUBB 5'h11
`define MCX_OP_SUBB_MEM 5'h12
`define MCX_OP_DSZ 5'h13
`define MCX_OP_DSZ_ACC 5'h14
`define MCX_OP_SET_BYTE 5'h15

// register file shape
`define MCX_RAM_AW 5
`define MCX_RAM_DEPTH 32
`define MCX_PC_W 10
`define MCX_ALL_ONES 8'hff
`define MCX_ACC_RST 8'h00

// machine states
`define MCX_ST_EXEC 2'h0
`define MCX_ST_DUMMY 2'h1
`define MCX_ST_POP2 2'h2

// command port
`define MCX_CMD_OP_LSB 0
`define MCX_CMD_ADDR_LSB 5
`define MCX_CMD_LIT_LSB 10

`endif

// ==== mcx_exec.v ====
// Overview of operation
// - copy memory to accumulator, flags untouched
// - load 8-bit literal into accumulator, flags untouched
// - copy accumulator into memory, flags untouched
// - idle only advances program counter, no flag change
// - or with memory or literal into accumulator, zero flag only
// - or result written to memory, zero flag only
// - plain return reloads counter from stack, two cycles, no flags
// - return with literal reloads counter and loads accumulator, no flags
// - rotate left bit 7 into bit 0, memory or accumulator, no flags
// - rotate left through carry, only carry changes
// - rotate right bit 0 into bit 7, memory or accumulator, no flags
// - rotate right through carry, only carry changes
// - subtract with carry: acc plus inverted memory plus carry; ov z ac c
// - memory variant of subtract writes result into memory
// - decrement memory, write back, skip next when zero, no flags
// - accumulator decrement variant keeps memory, same skip
// - skip discards prefetched instruction and inserts a dummy cycle
// - set byte writes all ones into memory
//
// Decided for this implementation: the address map and strobed register access.
`include "mcx_defs.vh"

module mcx_exec #(
    parameter RAM_AW = `MCX_RAM_AW,
    parameter RAM_DEPTH = `MCX_RAM_DEPTH,
    parameter PC_W = `MCX_PC_W
) (
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire instr_valid_i,
    input wire [4:0] instr_op_i,
    input wire [RAM_AW-1:0] instr_addr_i,
    input wire [7:0] instr_lit_i,
    input wire [PC_W-1:0] stack_top_i,
    input wire [RAM_AW-1:0] sw_addr_i,
    input wire [7:0] sw_wdata_i,
    input wire sw_wr_i,
    input wire sw_rd_i,
    output reg [7:0] sw_rdata_o,
    output wire instr_ready_o,
    output wire discard_prefetch_o,
    output reg [PC_W-1:0] pc_o,
    output reg [7:0] acc_o,
    output reg carry_o,
    output reg zero_o,
    output reg ovf_o,
    output reg aux_carry_o,
    output wire [1:0] state_o
);

    reg [7:0] ram_q [0:RAM_DEPTH-1];
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [PC_W-1:0] pc_d;
    reg [7:0] acc_d;
    reg c_d;
    reg z_d;
    reg ov_d;
    reg ac_d;
    reg mem_we;
    reg [7:0] mem_wd;
    reg [7:0] res;
    reg skip;
    wire [7:0] m;
    wire [7:0] nm;
    wire [4:0] lo_sum;
    wire [7:0] hi7_sum;
    wire [8:0] full_sum;
    wire [7:0] dec;
    wire exec;

    assign m = ram_q[instr_addr_i];
    assign nm = ~m;
    // subtract: acc + ~m + c
    assign lo_sum = {1'b0, acc_o[3:0]} + {1'b0, nm[3:0]} + {4'h0, carry_o};
    assign hi7_sum = {1'b0, acc_o[6:0]} + {1'b0, nm[6:0]} + {7'h00, carry_o};
    assign full_sum = {1'b0, acc_o} + {1'b0, nm} + {8'h00, carry_o};
    assign dec = m - 8'h01;
    assign instr_ready_o = (st_q == `MCX_ST_EXEC);
    assign exec = instr_valid_i && instr_ready_o;
    assign discard_prefetch_o = exec && skip;
    assign state_o = st_q;

    always @* begin
        st_d = st_q;
        pc_d = pc_o;
        acc_d = acc_o;
        c_d = carry_o;
        z_d = zero_o;
        ov_d = ovf_o;
        ac_d = aux_carry_o;
        mem_we = 1'b0;
        mem_wd = 8'h00;
        res = 8'h00;
        skip = 1'b0;
        if (st_q == `MCX_ST_DUMMY) begin
            st_d = `MCX_ST_EXEC;
        end else if (st_q == `MCX_ST_POP2) begin
            st_d = `MCX_ST_EXEC;
        end else if (exec) begin
            pc_d = pc_o + {{(PC_W-1){1'b0}}, 1'b1};
            case (instr_op_i)
                `MCX_OP_IDLE: begin
                    res = 8'h00;
                end
                `MCX_OP_COPY_MEM_ACC: begin
                    acc_d = m;
                end
                `MCX_OP_COPY_LIT_ACC: begin
                    acc_d = instr_lit_i;
                end
                `MCX_OP_COPY_ACC_MEM: begin
                    mem_we = 1'b1;
                    mem_wd = acc_o;
                end
                `MCX_OP_OR_MEM, `MCX_OP_OR_LIT, `MCX_OP_OR_TO_MEM: begin
                    res = acc_o | ((instr_op_i == `MCX_OP_OR_LIT) ? instr_lit_i : m);
                    z_d = (res == 8'h00);
                    if (instr_op_i == `MCX_OP_OR_TO_MEM) begin
                        mem_we = 1'b1;
                        mem_wd = res;
                    end else begin
                        acc_d = res;
                    end
                end
                `MCX_OP_POP_PC, `MCX_OP_POP_PC_LIT: begin
                    pc_d = stack_top_i;
                    st_d = `MCX_ST_POP2;
                    if (instr_op_i == `MCX_OP_POP_PC_LIT) begin
                        acc_d = instr_lit_i;
                    end
                end
                `MCX_OP_ROL, `MCX_OP_ROL_ACC: begin
                    res = {m[6:0], m[7]};
                    if (instr_op_i == `MCX_OP_ROL_ACC) begin
                        acc_d = res;
                    end else begin
                        mem_we = 1'b1;
                        mem_wd = res;
                    end
                end
                `MCX_OP_ROLC, `MCX_OP_ROLC_ACC: begin
                    res = {m[6:0], carry_o};
                    c_d = m[7];
                    if (instr_op_i == `MCX_OP_ROLC_ACC) begin
                        acc_d = res;
                    end else begin
                        mem_we = 1'b1;
                        mem_wd = res;
                    end
                end
                `MCX_OP_ROR, `MCX_OP_ROR_ACC: begin
                    res = {m[0], m[7:1]};
                    if (instr_op_i == `MCX_OP_ROR_ACC) begin
                        acc_d = res;
                    end else begin
                        mem_we = 1'b1;
                        mem_wd = res;
                    end
                end
                `MCX_OP_RORC, `MCX_OP_RORC_ACC: begin
                    res = {carry_o, m[7:1]};
                    c_d = m[0];
                    if (instr_op_i == `MCX_OP_RORC_ACC) begin
                        acc_d = res;
                    end else begin
                        mem_we = 1'b1;
                        mem_wd = res;
                    end
                end
                `MCX_OP_SUBB, `MCX_OP_SUBB_MEM: begin
                    res = full_sum[7:0];
                    c_d = full_sum[8];
                    ac_d = lo_sum[4];
                    z_d = (full_sum[7:0] == 8'h00);
                    ov_d = full_sum[8] ^ hi7_sum[7];
                    if (instr_op_i == `MCX_OP_SUBB_MEM) begin
                        mem_we = 1'b1;
                        mem_wd = res;
                    end else begin
                        acc_d = res;
                    end
                end
                `MCX_OP_DSZ, `MCX_OP_DSZ_ACC: begin
                    skip = (dec == 8'h00);
                    if (instr_op_i == `MCX_OP_DSZ_ACC) begin
                        acc_d = dec;
                    end else begin
                        mem_we = 1'b1;
                        mem_wd = dec;
                    end
                    if (skip) begin
                        pc_d = pc_o + {{(PC_W-2){1'b0}}, 2'b10};
                        st_d = `MCX_ST_DUMMY;
                    end
                end
                `MCX_OP_SET_BYTE: begin
                    mem_we = 1'b1;
                    mem_wd = `MCX_ALL_ONES;
                end
                default: begin
                    res = 8'h00;
                end
            endcase
        end
    end

    always @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            st_q <= `MCX_ST_EXEC;
            pc_o <= {PC_W{1'b0}};
            acc_o <= `MCX_ACC_RST;
            carry_o <= 1'b0;
            zero_o <= 1'b0;
            ovf_o <= 1'b0;
            aux_carry_o <= 1'b0;
            sw_rdata_o <= 8'h00;
        end else begin
            st_q <= st_d;
            pc_o <= pc_d;
            acc_o <= acc_d;
            carry_o <= c_d;
            zero_o <= z_d;
            ovf_o <= ov_d;
            aux_carry_o <= ac_d;
            sw_rdata_o <= sw_rd_i ? ram_q[sw_addr_i] : 8'h00;
        end
    end

    // data memory: instruction write wins over software write
    always @(posedge ref_clk_i) begin
        if (rst_n_i && mem_we) begin
            ram_q[instr_addr_i] <= mem_wd;
        end else if (rst_n_i && sw_wr_i) begin
            ram_q[sw_addr_i] <= sw_wdata_i;
        end
    end

endmodule

// ==== mcx_exec_assertions.sv ====
`include "mcx_defs.vh"
module mcx_exec_checker #(parameter PC_W = 10) (
    input logic ref_clk_i,
    input logic rst_n_i,
    input logic instr_valid_i,
    input logic [4:0] instr_op_i,
    input logic [7:0] instr_lit_i,
    input logic [PC_W-1:0] stack_top_i,
    input logic instr_ready_o,
    input logic discard_prefetch_o,
    input logic [PC_W-1:0] pc_o,
    input logic [7:0] acc_o,
    input logic carry_o,
    input logic zero_o,
    input logic ovf_o,
    input logic aux_carry_o,
    input logic [1:0] state_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    wire tk = instr_valid_i && instr_ready_o;
    wire [4:0] op = instr_op_i;
    wire [3:0] flg = {carry_o, zero_o, ovf_o, aux_carry_o};
    property p_idle;
        tk && op == `MCX_OP_IDLE |=> pc_o == $past(pc_o) + 1'b1 && $stable(acc_o) && $stable(flg);
    endproperty
    a_idle: assert property (p_idle) else $error("idle changed state");
    property p_lit;
        tk && op == `MCX_OP_COPY_LIT_ACC |=> acc_o == $past(instr_lit_i) && $stable(flg);
    endproperty
    a_lit: assert property (p_lit) else $error("literal load wrong");
    property p_ret;
        tk && op == `MCX_OP_POP_PC |=> pc_o == $past(stack_top_i) && !instr_ready_o && $stable(flg) ##1 instr_ready_o;
    endproperty
    a_ret: assert property (p_ret) else $error("return wrong");
    property p_retlit;
        tk && op == `MCX_OP_POP_PC_LIT |=> pc_o == $past(stack_top_i) && acc_o == $past(instr_lit_i) && $stable(flg);
    endproperty
    a_retlit: assert property (p_retlit) else $error("return with literal wrong");
    property p_orlit;
        tk && op == `MCX_OP_OR_LIT |=> acc_o == $past(acc_o | instr_lit_i) && zero_o == (acc_o == 8'h00)
            && $stable({carry_o, ovf_o, aux_carry_o});
    endproperty
    a_orlit: assert property (p_orlit) else $error("or literal wrong");
    property p_skip;
        discard_prefetch_o |=> pc_o == $past(pc_o) + 2'd2 && state_o == `MCX_ST_DUMMY && !instr_ready_o ##1 instr_ready_o;
    endproperty
    a_skip: assert property (p_skip) else $error("skip timing wrong");
    property p_one;
        tk && !discard_prefetch_o && op != `MCX_OP_POP_PC && op != `MCX_OP_POP_PC_LIT
            |=> instr_ready_o && pc_o == $past(pc_o) + 1'b1;
    endproperty
    a_one: assert property (p_one) else $error("single cycle step wrong");
    property p_keep;
        tk && (op == `MCX_OP_COPY_MEM_ACC || op == `MCX_OP_COPY_ACC_MEM) |=> $stable(flg);
    endproperty
    a_keep: assert property (p_keep) else $error("copy changed flags");
    property p_dsz;
        tk && (op == `MCX_OP_DSZ || op == `MCX_OP_DSZ_ACC) |=> $stable(flg);
    endproperty
    a_dsz: assert property (p_dsz) else $error("decrement changed flags");
    property p_rot;
        tk && (op == `MCX_OP_ROL || op == `MCX_OP_ROL_ACC || op == `MCX_OP_ROR || op == `MCX_OP_ROR_ACC)
            |=> $stable(flg);
    endproperty
    a_rot: assert property (p_rot) else $error("plain rotate changed flags");
    property p_rotc;
        tk && (op == `MCX_OP_ROLC || op == `MCX_OP_ROLC_ACC || op == `MCX_OP_RORC || op == `MCX_OP_RORC_ACC)
            |=> $stable({zero_o, ovf_o, aux_carry_o});
    endproperty
    a_rotc: assert property (p_rotc) else $error("carry rotate changed other flags");
    property p_ormem;
        tk && (op == `MCX_OP_OR_MEM || op == `MCX_OP_OR_TO_MEM || op == `MCX_OP_SET_BYTE)
            |=> $stable({carry_o, ovf_o, aux_carry_o});
    endproperty
    a_ormem: assert property (p_ormem) else $error("merge or set changed other flags");
    c_skip: cover property (discard_prefetch_o);
    c_retlit: cover property (tk && op == `MCX_OP_POP_PC_LIT);
    c_subm: cover property (tk && op == `MCX_OP_SUBB_MEM);
endmodule
bind mcx_exec mcx_exec_checker #(.PC_W(PC_W)) u_mcx_exec_checker (.*);

// ==== mcx_fetch_model.sv ====
module mcx_fetch_model #(parameter PC_W = 10, parameter RET_PC = 10'h01e) (
    input logic rst_n_i,
    input logic hold_i,
    input logic [PC_W-1:0] pc_i,
    output logic instr_valid_o,
    output logic [17:0] instr_o,
    output logic [PC_W-1:0] stack_top_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] prog [0:31];
    // stall while held; fields turn over so no stale word lingers
    assign instr_valid_o = rst_n_i && !hold_i;
    assign instr_o = hold_i ? ~prog[pc_i[4:0]] : prog[pc_i[4:0]];
    assign stack_top_o = RET_PC;
endmodule

// ==== tb_top.sv ====
`include "mcx_defs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 0, rst_n_i = 0, hold = 1, sw_wr_i = 0, sw_rd_i = 0;
    logic [4:0] sw_addr_i = 0;
    logic [7:0] sw_wdata_i = 0, sw_rdata_o, acc_o;
    logic [17:0] w;
    logic [9:0] stack_top_i, pc_o;
    logic instr_valid_i, instr_ready_o, discard_prefetch_o, carry_o, zero_o, ovf_o, aux_carry_o;
    logic [1:0] state_o;
    int mismatches = 0, check_count = 0;
    always #5 ref_clk_i = ~ref_clk_i;
    mcx_fetch_model u_mcx_fetch_model (.rst_n_i(rst_n_i), .hold_i(hold), .pc_i(pc_o),
        .instr_valid_o(instr_valid_i), .instr_o(w), .stack_top_o(stack_top_i));
    mcx_exec u_mcx_exec (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .instr_valid_i(instr_valid_i),
        .instr_op_i(w[17:13]), .instr_addr_i(w[12:8]), .instr_lit_i(w[7:0]), .stack_top_i(stack_top_i),
        .sw_addr_i(sw_addr_i), .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i),
        .sw_rdata_o(sw_rdata_o), .instr_ready_o(instr_ready_o), .discard_prefetch_o(discard_prefetch_o),
        .pc_o(pc_o), .acc_o(acc_o), .carry_o(carry_o), .zero_o(zero_o), .ovf_o(ovf_o),
        .aux_carry_o(aux_carry_o), .state_o(state_o));
    task chk(string n, logic [9:0] s, logic [9:0] e);
        check_count++;
        if (s !== e) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask
    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task p(int i, logic [4:0] o, logic [4:0] a, logic [7:0] l);
        u_mcx_fetch_model.prog[i] = {o, a, l};
    endtask
    task wr(logic [4:0] a, logic [7:0] d);
        @(posedge ref_clk_i);
        sw_wr_i <= 1;
        sw_addr_i <= a;
        sw_wdata_i <= d;
        @(posedge ref_clk_i);
        sw_wr_i <= 0;
    endtask
    task rd(logic [4:0] a, logic [7:0] e);
        @(posedge ref_clk_i);
        sw_rd_i <= 1;
        sw_addr_i <= a;
        @(posedge ref_clk_i);
        sw_rd_i <= 0;
        #1 chk("sw_rdata", sw_rdata_o, e);
    endtask
    logic [7:0] init_v [8] = '{8'h81, 8'h01, 8'h3c, 8'h05, 8'h01, 8'h01, 8'haa, 8'haa};
    logic [7:0] exp_v [8] = '{8'hfb, 8'hff, 8'h79, 8'hff, 8'h00, 8'h00, 8'h00, 8'haa};
    initial begin
        int n;
        p(0, `MCX_OP_COPY_LIT_ACC, 0, 8'h40);
        p(1, `MCX_OP_OR_MEM, 2, 0);
        p(2, `MCX_OP_OR_TO_MEM, 0, 0);
        p(3, `MCX_OP_ROL, 0, 0);
        p(4, `MCX_OP_RORC, 1, 0);
        p(5, `MCX_OP_ROLC_ACC, 2, 0);
        p(6, `MCX_OP_ROR_ACC, 0, 0);
        p(7, `MCX_OP_RORC_ACC, 3, 0);
        p(8, `MCX_OP_ROLC, 2, 0);
        p(9, `MCX_OP_SUBB, 1, 0);
        p(10, `MCX_OP_SUBB_MEM, 4, 0);
        p(11, `MCX_OP_DSZ, 1, 0);
        p(12, `MCX_OP_DSZ_ACC, 5, 0);
        p(13, `MCX_OP_SET_BYTE, 7, 0);
        p(14, `MCX_OP_DSZ, 5, 0);
        p(15, `MCX_OP_SET_BYTE, 7, 0);
        p(16, `MCX_OP_OR_LIT, 0, 8'h00);
        p(17, `MCX_OP_COPY_ACC_MEM, 6, 0);
        p(18, `MCX_OP_COPY_MEM_ACC, 0, 0);
        p(19, `MCX_OP_SET_BYTE, 3, 0);
        p(20, `MCX_OP_IDLE, 0, 0);
        p(21, `MCX_OP_POP_PC_LIT, 0, 8'h5a);
        p(30, `MCX_OP_POP_PC, 0, 0);
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1;
        for (n = 0; n < 8; n++) wr(n[4:0], init_v[n]);
        @(posedge ref_clk_i);
        hold <= 0;
        for (n = 0; n < 200 && pc_o !== 10'h01e; n++) @(posedge ref_clk_i) #1;
        chk("cycles", n, 22);
        @(posedge ref_clk_i);
        hold <= 1;
        #1 chk("acc", acc_o, 8'h5a);
        chk("flags", {carry_o, zero_o, ovf_o, aux_carry_o}, 4'hd);
        for (n = 0; n < 8; n++) rd(n[4:0], exp_v[n]);
        @(posedge ref_clk_i);
        hold <= 0;
        @(posedge ref_clk_i);
        hold <= 1;
        #1 chk("ret_state", {8'h00, state_o}, 10'h002);
        chk("ret_pc", pc_o, 10'h01e);
        chk("rdata_idle", {2'b00, sw_rdata_o}, 10'h000);
        @(posedge ref_clk_i);
        #1 chk("ret_ready", {9'h000, instr_ready_o}, 10'h001);
        report_and_stop;
    end
endmodule
